// [otp_prog_host.sv]
// Host that drives the PROM programming pins
`timescale 1ns/100ps
module otp_prog_host #(
    parameter int PULSE_CYCLES = otp_prog_pkg::PULSE_CYC,
    parameter int TRIES = otp_prog_pkg::MAX_TRIES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire otp_prog_pkg::op_t req_op_i,
    input wire logic [16:0] req_addr_i,
    input wire logic [31:0] req_data_i,
    output logic done_o,
    output otp_prog_pkg::result_t result_o,
    output logic [16:0] address_lines_o,
    output logic [7:0] data_lines_o,
    output logic data_lines_oe_o,
    input wire logic [7:0] data_lines_i,
    output otp_prog_pkg::strobe_t strobe_o
);
    typedef enum {
        S_IDLE, S_SETUP, S_LATCH, S_PULSE, S_VERIFY, S_NEXT, S_READ, S_DONE
    } state_t;

    state_t state_reg, state_next;
    logic [7:0] d_s1_reg, d_s2_reg;
    logic [31:0] buf_reg;
    logic [16:0] addr_reg, addr_next;
    logic [1:0] op_reg;
    logic [15:0] cnt_reg, cnt_next;
    logic [3:0] try_reg, try_next;
    logic [1:0] idx_reg, idx_next;
    logic ok_reg, ok_next;
    logic [7:0] rd_reg, rd_next;
    logic done_reg, done_next;

    wire is_page = (op_reg == 2'(otp_prog_pkg::OP_PAGE));
    wire is_read = (op_reg == 2'(otp_prog_pkg::OP_READ));
    wire cnt_end = (cnt_reg == 16'h0000);
    wire [7:0] cur_byte = buf_reg[8 * idx_reg +: 8];
    wire [16:0] cur_addr = is_page ? {addr_reg[16:2], idx_reg} : addr_reg; // R15
    wire addr_ok = (req_addr_i <= otp_prog_pkg::ADDR_LAST); // R13
    wire match = (d_s2_reg == cur_byte);

    function automatic logic [15:0] cyc(input int n);
        cyc = 16'(n - 1);
    endfunction

    assign req_ready_o = (state_reg == S_IDLE);
    assign done_o = done_reg;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            d_s1_reg <= 8'h00;
            d_s2_reg <= 8'h00;
        end
        else
        begin
            d_s1_reg <= data_lines_i;
            d_s2_reg <= d_s1_reg;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= S_IDLE;
            addr_reg <= 17'h00000;
            buf_reg <= 32'h00000000;
            op_reg <= 2'h0;
            cnt_reg <= 16'h0000;
            try_reg <= 4'h0;
            idx_reg <= 2'h0;
            ok_reg <= 1'b0;
            rd_reg <= 8'h00;
            done_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            cnt_reg <= cnt_next;
            try_reg <= try_next;
            idx_reg <= idx_next;
            ok_reg <= ok_next;
            rd_reg <= rd_next;
            done_reg <= done_next;
            if (state_reg == S_IDLE && req_valid_i)
            begin
                buf_reg <= req_data_i;
                op_reg <= req_op_i;
            end
        end
    end

    always_comb
    begin
        state_next = state_reg;
        addr_next = addr_reg;
        cnt_next = cnt_end ? cnt_reg : cnt_reg - 16'h0001;
        try_next = try_reg;
        idx_next = idx_reg;
        ok_next = ok_reg;
        rd_next = rd_reg;
        done_next = 1'b0;
        case (state_reg)
            S_IDLE:
                if (req_valid_i)
                begin
                    idx_next = 2'h0;
                    try_next = 4'h0;
                    ok_next = 1'b0;
                    cnt_next = cyc(otp_prog_pkg::SETUP_CYC);
                    if (req_op_i == otp_prog_pkg::OP_READ)
                    begin
                        // Address pins settle a cycle late, then two sync flops
                        cnt_next = cyc(otp_prog_pkg::SAMPLE_CYC);
                        addr_next = req_addr_i;
                        state_next = S_READ;
                    end
                    else if (!addr_ok)
                        state_next = S_DONE; // R13
                    else
                    begin
                        addr_next = req_addr_i;
                        state_next = (req_op_i == otp_prog_pkg::OP_PAGE) ?
                            S_LATCH : S_SETUP;
                    end
                end
            S_LATCH:
                if (cnt_end)
                begin
                    cnt_next = cyc(otp_prog_pkg::SETUP_CYC);
                    if (idx_reg == 2'(otp_prog_pkg::PAGE_BYTES - 1))
                    begin
                        idx_next = 2'h0;
                        state_next = S_SETUP;
                    end
                    else
                        idx_next = idx_reg + 2'h1; // R5
                end
            S_SETUP:
                if (cnt_end)
                begin
                    cnt_next = cyc(PULSE_CYCLES);
                    try_next = try_reg + 4'h1;
                    state_next = S_PULSE;
                end
            S_PULSE:
                if (cnt_end)
                begin
                    cnt_next = cyc(otp_prog_pkg::SAMPLE_CYC);
                    state_next = S_VERIFY; // R9
                end
            S_VERIFY:
                if (cnt_end)
                begin
                    cnt_next = cyc(otp_prog_pkg::SAMPLE_CYC);
                    if (!match)
                    begin
                        idx_next = 2'h0;
                        cnt_next = cyc(otp_prog_pkg::SETUP_CYC);
                        state_next = (try_reg == 4'(TRIES)) ? S_DONE :
                            (is_page ? S_LATCH : S_SETUP); // R10
                    end
                    else if (is_page && idx_reg != 2'h3)
                        idx_next = idx_reg + 2'h1;
                    else
                    begin
                        ok_next = 1'b1;
                        state_next = S_DONE;
                    end
                end
            S_READ:
                if (cnt_end)
                begin
                    rd_next = d_s2_reg; // R14
                    ok_next = 1'b1;
                    state_next = S_DONE;
                end
            S_DONE:
            begin
                done_next = 1'b1;
                state_next = S_IDLE;
            end
            default:
                state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            strobe_o <= '{ce_n: 1'b1, oe_n: 1'b1, pgm_n: 1'b1, hv: 1'b0,
                           rst_n: 1'b0};
            address_lines_o <= 17'h00000;
            data_lines_o <= 8'h00;
            data_lines_oe_o <= 1'b0;
            result_o <= '0;
        end
        else
        begin
            // Reset pin held low throughout; supply raised only to write
            strobe_o.rst_n <= 1'b0; // R1
            strobe_o.hv <= !is_read && state_next != S_IDLE; // R1
            address_lines_o <= cur_addr;
            data_lines_o <= cur_byte;
            case (state_next)
                S_LATCH:
                    strobe_o <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0}; // R5
                // Page pulse keeps chip select high, byte pulse pulls it low
                S_SETUP:
                    strobe_o <= '{is_page, 1'b1, 1'b1, 1'b1, 1'b0};
                S_PULSE:
                    strobe_o <= '{is_page, 1'b1, 1'b0, 1'b1, 1'b0}; // R6 R7
                S_VERIFY:
                    strobe_o <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0}; // R8
                S_READ:
                    strobe_o <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0}; // R2 R12
                default:
                    strobe_o <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0}; // R4 R11
            endcase
            data_lines_oe_o <= (state_next == S_LATCH) ||
                (state_next == S_SETUP) || (state_next == S_PULSE); // R3
            if (done_next)
                result_o <= '{ok: ok_reg, tries: try_reg, data: rd_reg};
        end
    end
endmodule // otp_prog_host

// [otp_prog_pkg.sv]
// Shared constants and types for the PROM programming host
// Functional notes
// [R1] Programming mode needs supply at 5 V or 12.5 V with reset pin low.
// [R2] Chip select and output drive low in read: device drives stored byte.
// [R3] Output drive high: device data lines high impedance, output disabled.
// [R4] Chip select high in read: standby, data lines high impedance.
// [R5] Page latch: chip select high, pulse high, output drive low; four bytes.
// [R6] After page latch, 0.1 ms low program pulse, select and drive high.
// [R7] Byte write: 0.1 ms low pulse, select low, drive high, data driven.
// [R8] Select low, pulse high, drive low: verify mode, device outputs data.
// [R9] Programmer runs verify after each write.
// [R10] Failed location retried write plus verify, at most 10 attempts total.
// [R11] A device whose pulse input stays high is not written.
// [R12] Programmer picks the single read device through output drive strobes.
// [R13] Program addresses only 0000H to 7FFFH, last address 7FFFH.
// [R14] Read presents address on seventeen lines, data returns on eight.
// [R15] Page holds four consecutive bytes aligned to a four-byte boundary.
package otp_prog_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int PAGE_BYTES = 4;
    localparam logic [16:0] ADDR_LAST = 17'h07FFF;
    localparam int MAX_TRIES = 10;
    localparam int CLK_NS = 100;
    localparam int PULSE_NS = 100000;
    localparam int PULSE_CYC = PULSE_NS / CLK_NS;
    localparam int SETUP_CYC = 2;
    localparam int SAMPLE_CYC = 4;

    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_BYTE = 2'h1,
        OP_PAGE = 2'h2
    } op_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic pgm_n;
        logic hv;
        logic rst_n;
    } strobe_t;

    typedef struct packed {
        logic ok;
        logic [3:0] tries;
        logic [7:0] data;
    } result_t;
endpackage

// [otp_prog_host_assertions.sv]
// Checker for the pins of the PROM programming host
`timescale 1ns/100ps
module otp_prog_host_assertions #(
    parameter int PULSE_CYCLES = 1000,
    parameter int TRIES = 10
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire otp_prog_pkg::op_t req_op_i,
    input wire logic done_o,
    input wire otp_prog_pkg::result_t result_o,
    input wire logic [16:0] address_lines_o,
    input wire logic data_lines_oe_o,
    input wire otp_prog_pkg::strobe_t strobe_o
);
    logic [15:0] low_reg;
    logic page_op_reg;
    always_ff @(posedge clk_i or posedge sys_rst_i)
        if (sys_rst_i)
            page_op_reg <= 1'b0;
        else if (req_valid_i && req_ready_o)
            page_op_reg <= (req_op_i == otp_prog_pkg::OP_PAGE);
    // Pulse length is counted here, a repetition could not hold 1000 cycles
    always_ff @(posedge clk_i or posedge sys_rst_i)
        if (sys_rst_i)
            low_reg <= 16'h0000;
        else
            low_reg <= strobe_o.pgm_n ? 16'h0000 : low_reg + 16'h0001;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_reset_pin_low: assert property (!strobe_o.rst_n)
        else $error("device reset pin not held low");
    a_pulse_width: assert property ($rose(strobe_o.pgm_n)
        |-> low_reg == PULSE_CYCLES) else $error("pulse width wrong");
    a_pulse_strobes: assert property (!strobe_o.pgm_n
        |-> strobe_o.oe_n && strobe_o.hv) else $error("pulse strobes");
    a_pulse_select: assert property (!strobe_o.pgm_n
        |-> strobe_o.ce_n == page_op_reg) else $error("pulse chip select");
    a_no_contention: assert property (data_lines_oe_o
        |-> strobe_o.oe_n || strobe_o.ce_n) else $error("bus contention");
    a_write_range: assert property (!strobe_o.pgm_n
        |-> address_lines_o <= 17'h07FFF) else $error("address range");
    a_read_latency: assert property (req_valid_i && req_ready_o &&
        req_op_i == otp_prog_pkg::OP_READ |-> ##6 done_o)
        else $error("read answer late");
    a_tries_bound: assert property (done_o |->
        result_o.tries <= TRIES) else $error("too many tries");
    a_verify_after: assert property ($rose(strobe_o.pgm_n) |->
        ##[1:8] !strobe_o.ce_n && !strobe_o.oe_n) else $error("no verify");
    a_verify_idle: assert property (!strobe_o.ce_n && !strobe_o.oe_n
        |-> strobe_o.pgm_n) else $error("pulse during verify");
endmodule // otp_prog_host_assertions
bind otp_prog_host otp_prog_host_assertions #(
    .PULSE_CYCLES(PULSE_CYCLES),
    .TRIES(TRIES)
) u_chk (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o),
    .req_op_i(req_op_i),
    .done_o(done_o),
    .result_o(result_o),
    .address_lines_o(address_lines_o),
    .data_lines_oe_o(data_lines_oe_o),
    .strobe_o(strobe_o)
);

// [otp_prom_model.sv]
// Behavioural PROM device on the far side of the programming pins
`timescale 1ns/100ps
module otp_prom_model (
    input wire logic clk_i,
    input wire otp_prog_pkg::strobe_t strobe_i,
    input wire logic [16:0] address_lines_i,
    input wire logic [7:0] host_data_i,
    input wire logic host_oe_i,
    input wire logic [3:0] fail_i,
    output logic [7:0] data_lines_o
);
    logic [7:0] mem [0:131071];
    logic [7:0] page_reg [0:3];
    logic [7:0] byte_reg, last_reg;
    logic [16:0] addr_reg;
    logic [3:0] fail_reg = 4'h0;
    logic [3:0] seen_reg = 4'h0;
    logic pgm_reg = 1'b1;
    logic hv_reg = 1'b0;
    logic page_reg_mode;
    wire sel = !strobe_i.ce_n && !strobe_i.oe_n && strobe_i.pgm_n;
    wire latch = strobe_i.ce_n && !strobe_i.oe_n && strobe_i.pgm_n;
    // A released bus shows the inverse of its last level, never stale data
    assign data_lines_o = host_oe_i ? host_data_i
        : sel ? mem[address_lines_i] : ~last_reg;
    initial
        foreach (mem[i]) mem[i] = 8'hFF;
    always @(posedge clk_i)
    begin
        last_reg <= data_lines_o;
        pgm_reg <= strobe_i.pgm_n;
        fail_reg <= fail_i;
        if (fail_i != fail_reg)
            seen_reg <= 4'h0;
        if (latch && strobe_i.hv)
            page_reg[address_lines_i[1:0]] <= host_data_i;
        if (!strobe_i.pgm_n)
        begin
            addr_reg <= address_lines_i;
            byte_reg <= host_data_i;
            page_reg_mode <= strobe_i.ce_n;
            hv_reg <= strobe_i.hv;
        end
        // Only a finished pulse writes, and cells only lose ones
        if (strobe_i.pgm_n && !pgm_reg && hv_reg)
        begin
            if (seen_reg < fail_i)
                seen_reg <= seen_reg + 4'h1;
            else if (page_reg_mode)
                for (int k = 0; k < 4; k++)
                    mem[{addr_reg[16:2], 2'(k)}] &= page_reg[k];
            else
                mem[addr_reg] &= byte_reg;
        end
    end
endmodule // otp_prom_model

// [test_otp_prom_programming_port.sv]
// Self-checking bench for the PROM programming host
`timescale 1ns/100ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin \
    num_errors++; $display("mismatch %0t %s", $time, m); end end
module test_otp_prom_programming_port;
    localparam otp_prog_pkg::op_t RD = otp_prog_pkg::OP_READ;
    localparam otp_prog_pkg::op_t BY = otp_prog_pkg::OP_BYTE;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    otp_prog_pkg::op_t req_op_i = RD;
    logic [16:0] req_addr_i = 17'h00000;
    logic [31:0] req_data_i = 32'h00000000;
    logic [3:0] fail_i = 4'h0;
    logic req_ready_o, done_o, data_lines_oe_o;
    logic [16:0] address_lines_o;
    logic [7:0] data_lines_o, data_lines_i;
    otp_prog_pkg::result_t result_o, res;
    otp_prog_pkg::strobe_t strobe_o;
    int num_errors = 0;
    int comparisons = 0;
    otp_prog_host #(.PULSE_CYCLES(4), .TRIES(10)) u_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_op_i(req_op_i),
        .req_addr_i(req_addr_i), .req_data_i(req_data_i),
        .done_o(done_o), .result_o(result_o),
        .address_lines_o(address_lines_o), .data_lines_o(data_lines_o),
        .data_lines_oe_o(data_lines_oe_o), .data_lines_i(data_lines_i),
        .strobe_o(strobe_o));
    otp_prom_model u_prom (
        .clk_i(clk_i), .strobe_i(strobe_o),
        .address_lines_i(address_lines_o), .host_data_i(data_lines_o),
        .host_oe_i(data_lines_oe_o), .fail_i(fail_i),
        .data_lines_o(data_lines_i));
    initial
        forever #50 clk_i = ~clk_i;
    task automatic close_out();
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic run(input otp_prog_pkg::op_t op, input logic [16:0] a,
        input logic [31:0] d);
        int n;
        req_op_i = op;
        req_addr_i = a;
        req_data_i = d;
        req_valid_i = 1'b1;
        @(posedge clk_i);
        #1 req_valid_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 2000)
        begin
            @(posedge clk_i);
            #1 n++;
        end
        res = result_o;
        if (n == 2000)
        begin
            num_errors++;
            close_out();
        end
    endtask
    task automatic t_read_erased();
        run(RD, 17'h00040, 32'h00000000);
        `CHK(res.data, 8'hFF, "erased read")
    endtask
    task automatic t_byte_once();
        run(BY, 17'h00123, 32'h0000005A);
        `CHK({res.ok, res.tries}, 5'h11, "byte write")
        run(RD, 17'h00123, 32'h00000000);
        `CHK(res.data, 8'h5A, "byte readback")
    endtask
    task automatic t_byte_retry();
        fail_i = 4'h3;
        run(BY, 17'h00200, 32'h000000C3);
        `CHK({res.ok, res.tries}, 5'h14, "retried write")
        fail_i = 4'hF;
        run(BY, 17'h00201, 32'h000000C3);
        `CHK({res.ok, res.tries}, 5'h0A, "stuck write")
        fail_i = 4'h0;
    endtask
    task automatic t_page_last();
        run(otp_prog_pkg::OP_PAGE, 17'h07FFF, 32'h44332211);
        `CHK({res.ok, res.tries}, 5'h11, "page write")
        for (int k = 0; k < 4; k++)
        begin
            run(RD, 17'h07FFC + 17'(k), 32'h00000000);
            `CHK(res.data, 8'(8'h11 * (k + 1)), "page byte")
        end
    endtask
    task automatic t_out_of_range();
        run(BY, 17'h08000, 32'h00000011);
        `CHK({res.ok, res.tries}, 5'h00, "range refused")
        run(RD, 17'h08000, 32'h00000000);
        `CHK(res.data, 8'hFF, "range untouched")
    endtask
    initial
    begin
        repeat (8) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        t_read_erased();
        t_byte_once();
        t_byte_retry();
        t_page_last();
        t_out_of_range();
        close_out();
    end
endmodule // test_otp_prom_programming_port
